//--- shared/upper_irq_defines.vh
// register offsets, field positions and reset values for the upper interrupt mapper
`ifndef UPPER_IRQ_DEFINES_VH
`define UPPER_IRQ_DEFINES_VH
// printed offsets are not all multiples of four: these are word indices, byte address = 4 * index
`define PIN1_UPPER_MASK_IDX 8'h3A
`define PIN2_UPPER_MASK_IDX 8'h3B
`define EVENT_FLAGS_IDX 8'h40
`define EVENT_CLEAR_IDX 8'h41
`define IRQ_STATUS_IDX 8'h42
`define IRQ_MASK_IDX 8'h43
`define UPPER_MASK_RESET 8'h00
`define UPPER_MASK_WR_BITS 8'hDF
`define BIT_FUSE_FAULT 7
`define BIT_USER_REG_FAULT 6
`define BIT_RESERVED 5
`define BIT_KEEPALIVE 4
`define BIT_AUX_ACTIVITY 3
`define BIT_AUX_INACTIVITY 2
`define BIT_DOUBLE_KNOCK 1
`define BIT_SINGLE_KNOCK 0
`define IRQ_STAT_PIN1 0
`define IRQ_STAT_PIN2 1
`define IRQ_STAT_KEEPALIVE 2
`define IRQ_STAT_RESET 3'h0
`define IRQ_MASK_RESET 3'h0
`define WB_UNMAPPED_DATA 32'h0000_0000
`endif

//--- rtl/event_flag_bit.v
// one sticky event flag: hardware set wins over clear
`timescale 1ns/1ps
`default_nettype none
module event_flag_bit (
    input wire clk_sys,
    input wire rst_n,
    input wire set_in,
    input wire clear_in,
    output reg flag_q
);
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_q <= 1'b0;
        end
        else if (set_in)
        begin
            flag_q <= 1'b1;
        end
        else if (clear_in)
        begin
            flag_q <= 1'b0;
        end
    end
endmodule // event_flag_bit
`default_nettype wire

//--- rtl/upper_interrupt_pin_mapper.v
// upper event group routed to two interrupt pins through two mask registers
`timescale 1ns/1ps
`default_nettype none
`include "upper_irq_defines.vh"
module upper_interrupt_pin_mapper (
    input wire clk_sys,
    input wire rst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire fuse_fault_evt,
    input wire user_reg_fault_evt,
    input wire aux_activity_evt,
    input wire aux_inactivity_evt,
    input wire double_knock_evt,
    input wire single_knock_evt,
    input wire keepalive_expiry_evt,
    input wire lower_pin1_req,
    input wire lower_pin2_req,
    output reg irq_pin_one,
    output reg irq_pin_two,
    output reg irq_o
);
    reg [7:0] pin1_upper_event_mask_q;
    reg [7:0] pin2_upper_event_mask_q;
    reg [2:0] irq_status_q;
    reg [2:0] irq_mask_q;
    reg [7:0] evt_meta_q;
    reg [7:0] evt_sync_q;
    reg [7:0] evt_prev_q;
    reg [1:0] lower_meta_q;
    reg [1:0] lower_sync_q;
    reg pin1_prev_q;
    reg pin2_prev_q;
    wire [7:0] raw_evt;
    wire [7:0] evt_rise;
    wire [7:0] src_flags;
    wire [7:0] flag_clear;
    wire [7:0] flag_q;
    wire [7:0] byte_idx;
    wire [31:0] mask_wr_data;
    wire wb_req;
    wire wb_wr;
    wire wb_rd;
    wire hit_flags;
    wire hit_clear;
    wire hit_mask1;
    wire hit_mask2;
    wire hit_stat;
    wire hit_imask;
    wire ka_pulse;
    reg pin1_d;
    reg pin2_d;
    reg [31:0] rd_d;

    // per-source enable fields, one per source and pin
    wire fuse_fault_to_pin1;
    wire fuse_fault_to_pin2;
    wire user_reg_fault_to_pin1;
    wire user_reg_fault_to_pin2;
    wire keepalive_expiry_to_pin1;
    wire keepalive_expiry_to_pin2;
    wire aux_activity_to_pin1;
    wire aux_activity_to_pin2;
    wire aux_inactivity_to_pin1;
    wire aux_inactivity_to_pin2;
    wire double_knock_to_pin1;
    wire double_knock_to_pin2;
    wire single_knock_to_pin1;
    wire single_knock_to_pin2;
    wire [7:0] pin1_enables;
    wire [7:0] pin2_enables;
    wire [7:0] route_one;
    wire [7:0] route_two;

    assign raw_evt = {fuse_fault_evt, user_reg_fault_evt, 1'b0, keepalive_expiry_evt,
                      aux_activity_evt, aux_inactivity_evt, double_knock_evt,
                      single_knock_evt};
    // events are pins from other logic domains, so each passes two flops first
    // the lower-group requests come from another block's clock and are treated alike
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            evt_meta_q <= 8'h00;
            evt_sync_q <= 8'h00;
            evt_prev_q <= 8'h00;
            lower_meta_q <= 2'b00;
            lower_sync_q <= 2'b00;
        end
        else
        begin
            evt_meta_q <= raw_evt;
            evt_sync_q <= evt_meta_q;
            evt_prev_q <= evt_sync_q;
            lower_meta_q <= {lower_pin2_req, lower_pin1_req};
            lower_sync_q <= lower_meta_q;
        end
    end
    assign evt_rise = evt_sync_q & ~evt_prev_q;

    // wishbone decode: byte address is four times the word index
    // the ack term keeps a strobe held through its ack from being taken twice
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
    assign wb_rd = wb_req && !wb_we_i;
    assign byte_idx = wb_adr_i[9:2];
    assign hit_mask1 = (wb_adr_i[1:0] == 2'b00) && (byte_idx == `PIN1_UPPER_MASK_IDX);
    assign hit_mask2 = (wb_adr_i[1:0] == 2'b00) && (byte_idx == `PIN2_UPPER_MASK_IDX);
    assign hit_flags = (wb_adr_i[1:0] == 2'b00) && (byte_idx == `EVENT_FLAGS_IDX);
    assign hit_clear = (wb_adr_i[1:0] == 2'b00) && (byte_idx == `EVENT_CLEAR_IDX);
    assign hit_stat = (wb_adr_i[1:0] == 2'b00) && (byte_idx == `IRQ_STATUS_IDX);
    assign hit_imask = (wb_adr_i[1:0] == 2'b00) && (byte_idx == `IRQ_MASK_IDX);
    assign mask_wr_data = wb_dat_i & {24'h0000_00, `UPPER_MASK_WR_BITS};

    // an expiry in the cycle of the read wins, so no event is lost
    // read clears keep-alive
    assign flag_clear[`BIT_KEEPALIVE] = wb_rd && hit_flags;
    assign flag_clear[`BIT_RESERVED] = 1'b0;
    // other sources are level copies held by their own detectors outside this block
    assign flag_clear[7:6] = 2'b00;
    assign flag_clear[3:0] = 4'h0;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_flag
            if (gi == `BIT_KEEPALIVE)
            begin : g_sticky
                event_flag_bit u_flag (
                    .clk_sys(clk_sys),
                    .rst_n(rst_n),
                    .set_in(evt_rise[gi]),
                    .clear_in(flag_clear[gi]),
                    .flag_q(flag_q[gi])
                );
            end
            else
            begin : g_level
                assign flag_q[gi] = (gi == `BIT_RESERVED) ? 1'b0 : evt_sync_q[gi];
            end
        end
    endgenerate
    assign src_flags = flag_q;
    assign ka_pulse = evt_rise[`BIT_KEEPALIVE];

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin1_upper_event_mask_q <= `UPPER_MASK_RESET;
            pin2_upper_event_mask_q <= `UPPER_MASK_RESET;
            irq_mask_q <= `IRQ_MASK_RESET;
        end
        else if (wb_wr)
        begin
            if (hit_mask1)
            begin
                pin1_upper_event_mask_q <= mask_wr_data[7:0];
            end
            else if (hit_mask2)
            begin
                pin2_upper_event_mask_q <= mask_wr_data[7:0];
            end
            else if (hit_imask)
            begin
                irq_mask_q <= wb_dat_i[2:0];
            end
        end
    end

    // named enable fields, taken from the stored masks
    // fuse to one
    assign fuse_fault_to_pin1 = pin1_upper_event_mask_q[`BIT_FUSE_FAULT];
    assign fuse_fault_to_pin2 = pin2_upper_event_mask_q[`BIT_FUSE_FAULT];
    assign user_reg_fault_to_pin1 = pin1_upper_event_mask_q[`BIT_USER_REG_FAULT];
    assign user_reg_fault_to_pin2 = pin2_upper_event_mask_q[`BIT_USER_REG_FAULT];
    assign keepalive_expiry_to_pin1 = pin1_upper_event_mask_q[`BIT_KEEPALIVE];
    assign keepalive_expiry_to_pin2 = pin2_upper_event_mask_q[`BIT_KEEPALIVE];
    assign aux_activity_to_pin1 = pin1_upper_event_mask_q[`BIT_AUX_ACTIVITY];
    assign aux_activity_to_pin2 = pin2_upper_event_mask_q[`BIT_AUX_ACTIVITY];
    assign aux_inactivity_to_pin1 = pin1_upper_event_mask_q[`BIT_AUX_INACTIVITY];
    assign aux_inactivity_to_pin2 = pin2_upper_event_mask_q[`BIT_AUX_INACTIVITY];
    assign double_knock_to_pin1 = pin1_upper_event_mask_q[`BIT_DOUBLE_KNOCK];
    assign double_knock_to_pin2 = pin2_upper_event_mask_q[`BIT_DOUBLE_KNOCK];
    assign single_knock_to_pin1 = pin1_upper_event_mask_q[`BIT_SINGLE_KNOCK];
    assign single_knock_to_pin2 = pin2_upper_event_mask_q[`BIT_SINGLE_KNOCK];

    // bit 5 is held low here as well, so a reserved bit can never route
    assign pin1_enables = {fuse_fault_to_pin1, user_reg_fault_to_pin1, 1'b0,
        keepalive_expiry_to_pin1, aux_activity_to_pin1, aux_inactivity_to_pin1,
        double_knock_to_pin1, single_knock_to_pin1};
    assign pin2_enables = {fuse_fault_to_pin2, user_reg_fault_to_pin2, 1'b0,
        keepalive_expiry_to_pin2, aux_activity_to_pin2, aux_inactivity_to_pin2,
        double_knock_to_pin2, single_knock_to_pin2};

    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_route
            assign route_one[gi] = src_flags[gi] & pin1_enables[gi];
            assign route_two[gi] = src_flags[gi] & pin2_enables[gi];
        end
    endgenerate

    always @*
    begin
        pin1_d = (|route_one) | lower_sync_q[0];
        pin2_d = (|route_two) | lower_sync_q[1];
    end

    // pins leave straight from flops so the host never sees decode glitches
    // mask only gates
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_pin_one <= 1'b0;
            irq_pin_two <= 1'b0;
            pin1_prev_q <= 1'b0;
            pin2_prev_q <= 1'b0;
        end
        else
        begin
            irq_pin_one <= pin1_d;
            irq_pin_two <= pin2_d;
            pin1_prev_q <= pin1_d;
            pin2_prev_q <= pin2_d;
        end
    end

    // sticky bus-side status: set beats the write-one clear in the same cycle
    // pin bits record rising edges, so a pin that stays high counts once
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_status_q <= `IRQ_STAT_RESET;
        end
        else
        begin
            irq_status_q[`IRQ_STAT_PIN1] <= (pin1_d && !pin1_prev_q) ||
                (irq_status_q[`IRQ_STAT_PIN1] &&
                 !(wb_wr && hit_stat && wb_dat_i[`IRQ_STAT_PIN1]));
            irq_status_q[`IRQ_STAT_PIN2] <= (pin2_d && !pin2_prev_q) ||
                (irq_status_q[`IRQ_STAT_PIN2] &&
                 !(wb_wr && hit_stat && wb_dat_i[`IRQ_STAT_PIN2]));
            irq_status_q[`IRQ_STAT_KEEPALIVE] <= ka_pulse ||
                (irq_status_q[`IRQ_STAT_KEEPALIVE] &&
                 !(wb_wr && hit_stat && wb_dat_i[`IRQ_STAT_KEEPALIVE]));
        end
    end

    // read mux; unmapped addresses still ack and return zero
    always @*
    begin
        rd_d = `WB_UNMAPPED_DATA;
        if (hit_mask1)
        begin
            rd_d = {24'h0000_00, pin1_upper_event_mask_q};
        end
        else if (hit_mask2)
        begin
            rd_d = {24'h0000_00, pin2_upper_event_mask_q};
        end
        // reading the flags is also what clears the keep-alive bit
        else if (hit_flags)
        begin
            rd_d = {24'h0000_00, src_flags};
        end
        else if (hit_stat)
        begin
            rd_d = {29'h0000_0000, irq_status_q};
        end
        else if (hit_imask)
        begin
            rd_d = {29'h0000_0000, irq_mask_q};
        end
        // spare word: answers zero and drops writes, like unmapped words
        else if (hit_clear)
        begin
            rd_d = `WB_UNMAPPED_DATA;
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            irq_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_rd ? rd_d : 32'h0000_0000;
            irq_o <= |(irq_status_q & irq_mask_q);
        end
    end
endmodule // upper_interrupt_pin_mapper
`default_nettype wire

//--- verification/upper_irq_asserts.sv
// port assertions for the upper interrupt mapper
`timescale 1ns/1ps
`default_nettype none
`include "upper_irq_defines.vh"
module upper_irq_asserts (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic fuse_fault_evt,
    input wire logic user_reg_fault_evt,
    input wire logic aux_activity_evt,
    input wire logic aux_inactivity_evt,
    input wire logic double_knock_evt,
    input wire logic single_knock_evt,
    input wire logic lower_pin1_req,
    input wire logic lower_pin2_req,
    input wire logic irq_pin_one,
    input wire logic irq_pin_two
);
    logic [7:0] idx_q;
    logic [7:0] m1_q;
    logic [7:0] m2_q;
    wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wr = take && wb_we_i && wb_sel_i[0];
    wire logic aligned = wb_adr_i[1:0] == 2'b00;
    wire logic [7:0] ev = {fuse_fault_evt, user_reg_fault_evt, 2'b00, aux_activity_evt,
        aux_inactivity_evt, double_knock_evt, single_knock_evt};
    // shadow masks so the pin checks follow software writes
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idx_q <= 8'h00;
            m1_q <= `UPPER_MASK_RESET;
            m2_q <= `UPPER_MASK_RESET;
        end
        else if (take)
        begin
            // a misaligned word is no register: the design answers zero
            idx_q <= aligned ? wb_adr_i[9:2] : 8'h00;
            if (wr && aligned && wb_adr_i[9:2] == `PIN1_UPPER_MASK_IDX)
                m1_q <= wb_dat_i[7:0] & `UPPER_MASK_WR_BITS;
            if (wr && aligned && wb_adr_i[9:2] == `PIN2_UPPER_MASK_IDX)
                m2_q <= wb_dat_i[7:0] & `UPPER_MASK_WR_BITS;
        end
    end
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence req_taken;
        take;
    endsequence
    sequence rd_ack;
        wb_ack_o && !wb_we_i;
    endsequence
    ack_pulse_a:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_latency_a:
        assert property (req_taken |=> wb_ack_o) else $error("ack late");
    idle_data_a:
        assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data idle");
    mask1_read_a:
        assert property (rd_ack ##0 idx_q == `PIN1_UPPER_MASK_IDX
            |-> wb_dat_o == {24'h00_0000, m1_q}) else $error("mask one readback");
    mask2_read_a:
        assert property (rd_ack ##0 idx_q == `PIN2_UPPER_MASK_IDX
            |-> wb_dat_o == {24'h00_0000, m2_q}) else $error("mask two readback");
    pin1_route_a:
        assert property ((|(ev & m1_q))[*3] |=> irq_pin_one) else $error("pin one low");
    pin2_route_a:
        assert property ((|(ev & m2_q))[*3] |=> irq_pin_two) else $error("pin two low");
    pin1_block_a:
        assert property ((!(|(ev & m1_q)) && !m1_q[4] && !lower_pin1_req)[*3]
            |=> !irq_pin_one) else $error("pin one high");
    pin2_block_a:
        assert property ((!(|(ev & m2_q)) && !m2_q[4] && !lower_pin2_req)[*3]
            |=> !irq_pin_two) else $error("pin two high");
endmodule // upper_irq_asserts
`default_nettype wire

//--- verification/irq_host_model.sv
// host side of the pins: counts rising edges seen on pin one
`timescale 1ns/1ps
`default_nettype none
module irq_host_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic irq_pin_one,
    output logic [7:0] rises_one
);
    logic prev_q;
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_q <= 1'b0;
            rises_one <= 8'h00;
        end
        else
        begin
            prev_q <= irq_pin_one;
            if (irq_pin_one && !prev_q)
                rises_one <= rises_one + 8'h01;
        end
    end
endmodule // irq_host_model
`default_nettype wire

//--- verification/upper_interrupt_pin_mapper_bench.sv
// self-checking bench for the upper interrupt mapper
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        n_checks++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("[FAIL] %s exp %0h got %0h", nm, e, g); \
        end \
    end
module upper_interrupt_pin_mapper_bench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0000_0000, wb_dat_i = 32'h0000_0000, wb_dat_o, rd, am;
    logic [3:0] wb_sel_i = 4'hF, sel_req = 4'hF;
    logic wb_ack_o, irq_pin_one, irq_pin_two, irq_o;
    logic fuse_fault_evt = 1'b0, user_reg_fault_evt = 1'b0, aux_activity_evt = 1'b0;
    logic aux_inactivity_evt = 1'b0, double_knock_evt = 1'b0, single_knock_evt = 1'b0;
    logic keepalive_expiry_evt = 1'b0, lower_pin1_req = 1'b0, lower_pin2_req = 1'b0;
    logic [7:0] rises_one, m;
    int mismatches = 0, n_checks = 0, b, p;
    upper_interrupt_pin_mapper DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fuse_fault_evt(fuse_fault_evt),
        .user_reg_fault_evt(user_reg_fault_evt), .aux_activity_evt(aux_activity_evt),
        .aux_inactivity_evt(aux_inactivity_evt), .double_knock_evt(double_knock_evt),
        .single_knock_evt(single_knock_evt), .keepalive_expiry_evt(keepalive_expiry_evt),
        .lower_pin1_req(lower_pin1_req), .lower_pin2_req(lower_pin2_req),
        .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two), .irq_o(irq_o)
    );
    irq_host_model host (
        .clk_sys(clk_sys), .rst_n(rst_n), .irq_pin_one(irq_pin_one), .rises_one(rises_one)
    );
    initial
        forever #50 clk_sys = ~clk_sys;
    task final_report;
        if (mismatches == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= sel_req;
        // ack is looked at on rising edges only; the request stands until then
        do
            @(posedge clk_sys);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        `CHK("read data", e, rd)
    endtask
    task automatic set_ev(input logic [7:0] v);
        @(posedge clk_sys);
        {fuse_fault_evt, user_reg_fault_evt} <= v[7:6];
        {aux_activity_evt, aux_inactivity_evt, double_knock_evt, single_knock_evt} <= v[3:0];
    endtask
    task automatic pins(input logic e1, input logic e2);
        repeat (5) @(posedge clk_sys);
        `CHK("pin one", e1, irq_pin_one)
        `CHK("pin two", e2, irq_pin_two)
    endtask
    initial
    begin
        repeat (10000) @(posedge clk_sys);
        mismatches++;
        final_report;
    end
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk(32'h0000_00E8, 32'h0000_0000);
        rd_chk(32'h0000_00EC, 32'h0000_0000);
        set_ev(8'hCF);
        pins(1'b0, 1'b0);
        for (p = 0; p < 2; p++)
            for (b = 0; b < 8; b++)
                if (b != 4 && b != 5)
                begin
                    m = 8'h01 << b;
                    am = p ? 32'h0000_00EC : 32'h0000_00E8;
                    wb(1'b1, am, {24'h00_0000, m});
                    set_ev(m);
                    pins(p == 0, p == 1);
                    set_ev(~m & 8'hCF);
                    pins(1'b0, 1'b0);
                    wb(1'b1, am, 32'h0000_0000);
                end
        set_ev(8'h00);
        sel_req = 4'hE;
        wb(1'b1, 32'h0000_00E8, 32'h0000_00FF);
        sel_req = 4'hF;
        rd_chk(32'h0000_00E8, 32'h0000_0000);
        wb(1'b1, 32'h0000_00E8, 32'h0000_00FF);
        rd_chk(32'h0000_00E8, 32'h0000_00DF);
        wb(1'b1, 32'h0000_00E8, 32'h0000_0010);
        @(posedge clk_sys) keepalive_expiry_evt <= 1'b1;
        @(posedge clk_sys) keepalive_expiry_evt <= 1'b0;
        pins(1'b1, 1'b0);
        wb(1'b1, 32'h0000_00E8, 32'h0000_0000);
        pins(1'b0, 1'b0);
        wb(1'b1, 32'h0000_00EC, 32'h0000_0010);
        pins(1'b0, 1'b1);
        rd_chk(32'h0000_0100, 32'h0000_0010);
        rd_chk(32'h0000_0100, 32'h0000_0000);
        pins(1'b0, 1'b0);
        rd_chk(32'h0000_0108, 32'h0000_0007);
        `CHK("irq", 1'b0, irq_o)
        wb(1'b1, 32'h0000_010C, 32'h0000_0004);
        repeat (3) @(posedge clk_sys);
        `CHK("irq", 1'b1, irq_o)
        wb(1'b1, 32'h0000_0108, 32'h0000_0004);
        repeat (3) @(posedge clk_sys);
        `CHK("irq", 1'b0, irq_o)
        rd_chk(32'h0000_0108, 32'h0000_0003);
        rd_chk(32'h0000_03FC, 32'h0000_0000);
        m = rises_one;
        lower_pin1_req <= 1'b1;
        lower_pin2_req <= 1'b1;
        pins(1'b1, 1'b1);
        `CHK("host rises", m + 8'h01, rises_one)
        final_report;
    end
endmodule // upper_interrupt_pin_mapper_bench
bind upper_interrupt_pin_mapper upper_irq_asserts checker_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fuse_fault_evt(fuse_fault_evt),
    .user_reg_fault_evt(user_reg_fault_evt), .aux_activity_evt(aux_activity_evt),
    .aux_inactivity_evt(aux_inactivity_evt), .double_knock_evt(double_knock_evt),
    .single_knock_evt(single_knock_evt), .lower_pin1_req(lower_pin1_req),
    .lower_pin2_req(lower_pin2_req), .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two)
);
`default_nettype wire
